// file: rtl/pin_sync_bank.sv
// three-stage synchroniser with agreement filter for trigger pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync_bank
    import scan_trigger_pkg::*;
#(
    parameter int W = PIN_W
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // pins in, filtered levels out
    pin_sync_if.bank  pins
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] level;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage1 <= {W{SYNC_RESET_LEVEL}};
            stage2 <= {W{SYNC_RESET_LEVEL}};
            stage3 <= {W{SYNC_RESET_LEVEL}};
        end else begin
            stage1 <= pins.raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level <= {W{SYNC_RESET_LEVEL}};
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

    assign pins.level = level;

endmodule
`default_nettype wire

// file: rtl/pin_sync_if.sv
// carrier between pin synchroniser bank and the trigger selector
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(
    parameter int W = 36
);
    logic [W-1:0] raw;
    logic [W-1:0] level;

    modport bank (input raw, output level);
    modport user (output raw, input level);
endinterface
`default_nettype wire

// file: rtl/scan_trigger_input_select.sv
// trigger input gate of the scan sequencer
//
// Summary of operation
// R1: With the no-wait source selected, a waiting scan entry is released at once without any trigger.
// R2: With the external source selected, the scan list holds until an edge arrives on the external input.
// R3: With the host command source selected, the scan list holds until the host issues its trigger command.
// R4: Eight backplane line sources, zero to seven, each hold the scan list until an edge on that line.
// R5: With the star line source selected, the scan list holds until an edge on the star trigger line.
// R6: Back panel and front panel connector sources each hold the scan list until an edge on that connector.
// R7: Twelve back panel and twelve front panel unit sources each hold until an edge from that unit.
// R8: The edge select chooses whether a rising or a falling edge of the selected input is a trigger.
// R9: Each recognised edge on the selected source releases at most one entry; other sources are ignored.
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_input_select
    import scan_trigger_pkg::*;
#(
    parameter int UNITS = PANEL_UNITS,
    parameter int LINES = BACKPLANE_LINES
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // configuration
    input  wire logic [SRC_W-1:0] scan_advance_source_select_i,
    input  wire logic             advance_edge_select_i,
    // trigger pins
    input  wire logic             external_trigger_i,
    input  wire logic [LINES-1:0] backplane_lines_i,
    input  wire logic             star_line_i,
    input  wire logic             back_panel_i,
    input  wire logic             front_panel_i,
    input  wire logic [UNITS-1:0] back_panel_units_i,
    input  wire logic [UNITS-1:0] front_panel_units_i,
    // host command, one-cycle pulse on clk_i
    input  wire logic             host_command_trigger_i,
    // scan sequencer handshake
    input  wire logic             entry_waiting_i,
    output logic                  advance_o,
    // status
    output logic                  trigger_pending_o,
    output logic                  trigger_overrun_o
);

    pin_sync_if #(.W(PIN_W)) pins ();

    assign pins.raw = {front_panel_units_i, back_panel_units_i, front_panel_i,
                       back_panel_i, star_line_i, backplane_lines_i, external_trigger_i};

    pin_sync_bank #(
        .W (PIN_W)
    ) pin_sync_bank_inst (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .pins   (pins)
    );

    // true for sources that watch a pin
    function automatic logic is_pin_source(input logic [SRC_W-1:0] code);
        return (code == SRC_EXTERNAL) ||
               ((code >= SRC_BACKPLANE_ZERO) && (code <= SRC_FRONT_UNIT_TWELVE));
    endfunction

    // pin vector index of a pin source; other codes fall back to a legal index
    function automatic logic [5:0] pin_index(input logic [SRC_W-1:0] code);
        if (code == SRC_EXTERNAL) begin
            return 6'(PIN_EXTERNAL);
        end else if ((code >= SRC_BACKPLANE_ZERO) && (code <= SRC_FRONT_UNIT_TWELVE)) begin
            return code - PIN_CODE_OFFSET;
        end else begin
            return 6'(PIN_EXTERNAL);
        end
    endfunction

    logic [SRC_W-1:0] src;
    logic [SRC_W-1:0] src_q;
    logic             src_stable;
    logic             pin_src;
    logic             sel_level;
    logic             prev_level;
    logic             edge_hit;
    logic             host_hit;
    logic             trig_event;
    logic             consume;
    trig_state_e      state;
    trig_state_e      next_state;

    assign src        = scan_advance_source_select_i;
    assign src_stable = (src == src_q);
    assign pin_src    = is_pin_source(src);
    assign sel_level  = pins.level[pin_index(src)];

    // only the selected pin is looked at
    always_comb begin
        edge_hit = 1'b0;
        if (pin_src && src_stable) begin
            if (advance_edge_select_i == EDGE_RISING) begin
                edge_hit = sel_level && !prev_level; // R8
            end else begin
                edge_hit = !sel_level && prev_level; // R8
            end
        end
    end

    assign host_hit   = (src == SRC_HOST_COMMAND) && host_command_trigger_i; // R3
    assign trig_event = edge_hit || host_hit; // R2 R4 R5 R6 R7 R9

    // previous level re-seeded on source change, so a switch is no edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_q      <= SRC_NO_WAIT;
            prev_level <= SYNC_RESET_LEVEL;
        end else begin
            src_q      <= src;
            prev_level <= sel_level;
        end
    end

    // release a waiting entry
    always_comb begin
        if (src == SRC_NO_WAIT) begin
            advance_o = entry_waiting_i; // R1
        end else begin
            advance_o = entry_waiting_i && (state == ST_PENDING); // R2 R3 R9
        end
    end

    assign consume = advance_o && (state == ST_PENDING);

    // one stored trigger; a new trigger beats the clear
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trig_event) begin
                    next_state = ST_PENDING;
                end
            end
            ST_PENDING: begin
                if (trig_event) begin
                    next_state = ST_PENDING;
                end else if (consume || !src_stable) begin
                    next_state = ST_IDLE; // R9
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // a trigger that finds one already stored and not taken is lost
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trigger_overrun_o <= 1'b0;
        end else begin
            trigger_overrun_o <= trig_event && (state == ST_PENDING) && !consume;
        end
    end

    assign trigger_pending_o = (state == ST_PENDING);

    property p_no_wait;
        @(posedge clk_i) disable iff (!nrst_i)
        (src == SRC_NO_WAIT) && entry_waiting_i |-> advance_o;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("no-wait source did not release entry"); // R1

    property p_external_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (src == SRC_EXTERNAL) && (state == ST_IDLE) |-> !advance_o;
    endproperty
    a_external_hold: assert property (p_external_hold) else $error("external source advanced untriggered"); // R2

    property p_host_release;
        @(posedge clk_i) disable iff (!nrst_i)
        ((src == SRC_HOST_COMMAND) && host_command_trigger_i) ##1
        ((src == SRC_HOST_COMMAND) && entry_waiting_i) |-> advance_o;
    endproperty
    a_host_release: assert property (p_host_release) else $error("host command did not release entry"); // R3

    property p_backplane_rise;
        @(posedge clk_i) disable iff (!nrst_i)
        (src >= SRC_BACKPLANE_ZERO) && (src <= SRC_BACKPLANE_SEVEN) && src_stable &&
        (advance_edge_select_i == EDGE_RISING) && sel_level && !prev_level |=> trigger_pending_o;
    endproperty
    a_backplane_rise: assert property (p_backplane_rise) else $error("backplane edge not stored"); // R4

    property p_star_fall;
        @(posedge clk_i) disable iff (!nrst_i)
        (src == SRC_STAR_LINE) && src_stable && (advance_edge_select_i == EDGE_FALLING) &&
        !sel_level && prev_level |=> trigger_pending_o;
    endproperty
    a_star_fall: assert property (p_star_fall) else $error("star line edge not stored"); // R5

    property p_panel_edge;
        @(posedge clk_i) disable iff (!nrst_i)
        ((src == SRC_BACK_PANEL) || (src == SRC_FRONT_PANEL)) && src_stable &&
        (advance_edge_select_i == EDGE_RISING) && $rose(sel_level) |=> trigger_pending_o;
    endproperty
    a_panel_edge: assert property (p_panel_edge) else $error("panel edge not stored"); // R6

    property p_unit_edge;
        @(posedge clk_i) disable iff (!nrst_i)
        (src >= SRC_BACK_UNIT_ONE) && (src <= SRC_FRONT_UNIT_TWELVE) && src_stable &&
        (advance_edge_select_i == EDGE_FALLING) && $fell(sel_level) |=> trigger_pending_o;
    endproperty
    a_unit_edge: assert property (p_unit_edge) else $error("panel unit edge not stored"); // R7

    property p_wrong_edge;
        @(posedge clk_i) disable iff (!nrst_i)
        pin_src && src_stable && (state == ST_IDLE) && (advance_edge_select_i == EDGE_RISING) &&
        !sel_level && prev_level |=> !trigger_pending_o;
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) else $error("opposite edge taken as trigger"); // R8

    property p_one_release;
        @(posedge clk_i) disable iff (!nrst_i)
        advance_o && (src != SRC_NO_WAIT) && !trig_event ##1 (src != SRC_NO_WAIT) |-> !advance_o;
    endproperty
    a_one_release: assert property (p_one_release) else $error("one trigger released two entries"); // R9

    property p_ignore_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == ST_IDLE) && pin_src && src_stable && (sel_level == prev_level) |=> !trigger_pending_o;
    endproperty
    a_ignore_idle: assert property (p_ignore_idle) else $error("trigger stored without selected edge"); // R9

endmodule
`default_nettype wire

// file: rtl/scan_trigger_pkg.sv
// constants for the scan trigger input select block
package scan_trigger_pkg;

    // source select encoding
    localparam int         SRC_W                   = 6;
    localparam logic [5:0] SRC_NO_WAIT             = 6'h00;
    localparam logic [5:0] SRC_EXTERNAL            = 6'h01;
    localparam logic [5:0] SRC_HOST_COMMAND        = 6'h02;
    localparam logic [5:0] SRC_BACKPLANE_ZERO      = 6'h03;
    localparam logic [5:0] SRC_BACKPLANE_SEVEN     = 6'h0a;
    localparam logic [5:0] SRC_STAR_LINE           = 6'h0b;
    localparam logic [5:0] SRC_BACK_PANEL          = 6'h0c;
    localparam logic [5:0] SRC_FRONT_PANEL         = 6'h0d;
    localparam logic [5:0] SRC_BACK_UNIT_ONE       = 6'h0e;
    localparam logic [5:0] SRC_BACK_UNIT_TWELVE    = 6'h19;
    localparam logic [5:0] SRC_FRONT_UNIT_ONE      = 6'h1a;
    localparam logic [5:0] SRC_FRONT_UNIT_TWELVE   = 6'h25;

    // pin vector layout (after synchronisation)
    localparam int         BACKPLANE_LINES         = 8;
    localparam int         PANEL_UNITS             = 12;
    localparam int         PIN_W                   = 4 + BACKPLANE_LINES + 2 * PANEL_UNITS;
    localparam int         PIN_EXTERNAL            = 0;
    localparam int         PIN_BACKPLANE_BASE      = 1;
    localparam int         PIN_STAR_LINE           = 9;
    localparam int         PIN_BACK_PANEL          = 10;
    localparam int         PIN_FRONT_PANEL         = 11;
    localparam int         PIN_BACK_UNIT_BASE      = 12;
    localparam int         PIN_FRONT_UNIT_BASE     = 24;
    // pin index of code c (c >= 3) is c minus this
    localparam logic [5:0] PIN_CODE_OFFSET         = 6'h02;

    // edge select encoding
    localparam logic       EDGE_RISING             = 1'b0;
    localparam logic       EDGE_FALLING            = 1'b1;

    // synchroniser reset level
    localparam logic       SYNC_RESET_LEVEL        = 1'b0;

    typedef enum logic [0:0] {
        ST_IDLE    = 1'b0,
        ST_PENDING = 1'b1
    } trig_state_e;

endpackage

// file: verification/scan_trigger_input_select_test.sv
// self-checking bench for the scan trigger input select block
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_input_select_test;
    import scan_trigger_pkg::*;

    logic             clk_i;
    logic             nrst_i;
    logic [SRC_W-1:0] src;
    logic             edge_sel;
    logic             host_cmd;
    logic             waiting;
    logic             advance;
    logic             pending;
    logic             overrun;
    logic             pol;
    logic [PIN_W-1:0] pins;
    int               failures;
    int               checks;
    logic [7:0]       cnt;
    int               p;
    int               q;

    initial clk_i = 1'b0;
    always #25 clk_i = ~clk_i;

    trigger_source_model trigger_source_model_inst (
        .clk_i  (clk_i),
        .pins_o (pins)
    );

    scan_trigger_input_select scan_trigger_input_select_inst (
        .clk_i                        (clk_i),
        .nrst_i                       (nrst_i),
        .scan_advance_source_select_i (src),
        .advance_edge_select_i        (edge_sel),
        .external_trigger_i           (pins[PIN_EXTERNAL]),
        .backplane_lines_i            (pins[PIN_BACKPLANE_BASE +: BACKPLANE_LINES]),
        .star_line_i                  (pins[PIN_STAR_LINE]),
        .back_panel_i                 (pins[PIN_BACK_PANEL]),
        .front_panel_i                (pins[PIN_FRONT_PANEL]),
        .back_panel_units_i           (pins[PIN_BACK_UNIT_BASE +: PANEL_UNITS]),
        .front_panel_units_i          (pins[PIN_FRONT_UNIT_BASE +: PANEL_UNITS]),
        .host_command_trigger_i       (host_cmd),
        .entry_waiting_i              (waiting),
        .advance_o                    (advance),
        .trigger_pending_o            (pending),
        .trigger_overrun_o            (overrun)
    );

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_count(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: advance count %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: flag %h, expected %h", $time, got, exp);
        end
    endtask

    // counts release pulses over a window longer than the pin path delay
    task automatic count_advances(output logic [7:0] n);
        n = 8'h00;
        repeat (14) begin
            @(negedge clk_i);
            if (advance === 1'b1) begin
                n = n + 8'h01;
            end
        end
    endtask

    task automatic set_src(input logic [SRC_W-1:0] code, input logic e, input logic w);
        @(posedge clk_i);
        waiting  <= 1'b0;
        src      <= code;
        edge_sel <= e;
        repeat (3) @(posedge clk_i);
        waiting <= w;
    endtask

    task automatic host_pulse();
        @(posedge clk_i);
        host_cmd <= 1'b1;
        @(posedge clk_i);
        host_cmd <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("mismatch at %0t: run limit %h reached, expected %h", $time, 1'b1, 1'b0);
        finish_test();
    end

    initial begin
        nrst_i   = 1'b0;
        src      = SRC_NO_WAIT;
        edge_sel = EDGE_RISING;
        host_cmd = 1'b0;
        waiting  = 1'b0;
        failures = 0;
        checks   = 0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;

        // no-wait source releases a waiting entry at once
        set_src(SRC_NO_WAIT, EDGE_RISING, 1'b1);
        @(negedge clk_i);
        cmp_flag(advance, 1'b1);
        @(posedge clk_i);
        waiting <= 1'b0;
        @(negedge clk_i);
        cmp_flag(advance, 1'b0);
        $display("test no_wait done");

        // every pin source: neighbour ignored, own edge releases one entry; odd codes watch falling edges
        for (int c = 1; c <= 37; c++) begin
            if (c == 2) begin
                continue;
            end
            p = (c == 1) ? PIN_EXTERNAL : c - 2;
            q = (p + 1) % PIN_W;
            pol = c[0];
            set_src(c[SRC_W-1:0], pol, 1'b1);
            trigger_source_model_inst.drive(q, 1'b1);
            count_advances(cnt);
            cmp_count(cnt, 8'h00);
            trigger_source_model_inst.drive(p, 1'b1);
            count_advances(cnt);
            cmp_count(cnt, (pol == EDGE_RISING) ? 8'h01 : 8'h00);
            trigger_source_model_inst.drive(p, 1'b0);
            trigger_source_model_inst.drive(q, 1'b0);
            count_advances(cnt);
            cmp_count(cnt, (pol == EDGE_FALLING) ? 8'h01 : 8'h00);
        end
        $display("test pin_sources done");

        // falling polarity, trigger held until the sequencer asks for it
        set_src(SRC_EXTERNAL, EDGE_FALLING, 1'b0);
        trigger_source_model_inst.drive(PIN_EXTERNAL, 1'b1);
        count_advances(cnt);
        cmp_flag(pending, 1'b0);
        trigger_source_model_inst.drive(PIN_EXTERNAL, 1'b0);
        count_advances(cnt);
        cmp_flag(pending, 1'b1);
        cmp_count(cnt, 8'h00);
        @(posedge clk_i);
        waiting <= 1'b1;
        count_advances(cnt);
        cmp_count(cnt, 8'h01);
        $display("test falling_edge done");

        // host command: ignored under another source, one release when selected
        set_src(SRC_EXTERNAL, EDGE_RISING, 1'b1);
        host_pulse();
        count_advances(cnt);
        cmp_count(cnt, 8'h00);
        set_src(SRC_HOST_COMMAND, EDGE_RISING, 1'b1);
        count_advances(cnt);
        cmp_count(cnt, 8'h00);
        host_pulse();
        count_advances(cnt);
        cmp_count(cnt, 8'h01);
        $display("test host_command done");

        // second trigger while one is stored is dropped and flagged
        @(posedge clk_i);
        waiting <= 1'b0;
        host_pulse();
        host_pulse();
        @(negedge clk_i);
        cmp_flag(overrun, 1'b1);
        @(negedge clk_i);
        cmp_flag(overrun, 1'b0);
        @(posedge clk_i);
        waiting <= 1'b1;
        count_advances(cnt);
        cmp_count(cnt, 8'h01);
        $display("test overrun done");

        // the first code past the last unit never releases
        set_src(SRC_FRONT_UNIT_TWELVE + 6'h01, EDGE_RISING, 1'b1);
        trigger_source_model_inst.drive(PIN_EXTERNAL, 1'b1);
        count_advances(cnt);
        cmp_count(cnt, 8'h00);
        trigger_source_model_inst.drive(PIN_EXTERNAL, 1'b0);
        $display("test unused_code done");

        finish_test();
    end
endmodule
`default_nettype wire

// file: verification/trigger_source_model.sv
// trigger source model: drives the trigger pin levels seen by the scan trigger input select block
`timescale 1ns/1ps
`default_nettype none
module trigger_source_model
    import scan_trigger_pkg::*;
(
    // clock
    input  wire logic            clk_i,
    // trigger pin levels
    output var  logic [PIN_W-1:0] pins_o
);
    initial pins_o = '0;

    // levels change just after a rising edge and are held until changed again
    task automatic drive(input int idx, input logic val);
        @(posedge clk_i);
        pins_o[idx] <= val;
    endtask
endmodule
`default_nettype wire
